// [rtl/pic_pkg.sv]
package pic_pkg;
   // Geometry of the controller.
   localparam int NCH = 64;
   localparam int NEXT_CH = 16;
   localparam int LVLW = 3;
   localparam int AW = 8;
   // Register byte addresses.
   localparam logic [7:0] OFF_FAST0 = 8'h00;
   localparam logic [7:0] OFF_FAST1 = 8'h04;
   localparam logic [7:0] OFF_NORM0 = 8'h08;
   localparam logic [7:0] OFF_NORM1 = 8'h0c;
   localparam logic [7:0] OFF_FVEC = 8'h10;
   localparam logic [7:0] OFF_NVEC = 8'h14;
   localparam logic [7:0] OFF_EN0 = 8'h18;
   localparam logic [7:0] OFF_EN1 = 8'h1c;
   localparam logic [7:0] OFF_CTL = 8'h20;
   localparam logic [7:0] OFF_BASE = 8'h24;
   localparam logic [7:0] OFF_PRIO0 = 8'h30;
   localparam logic [7:0] OFF_PRIO7 = 8'h4c;
   localparam logic [7:0] OFF_EVST = 8'h50;
   localparam logic [7:0] OFF_EVMASK = 8'h54;
   // Field layout.
   localparam int CTL_SIZE_LSB = 0;
   localparam int PRIO_NIB = 4;
   localparam int PRIO_PER_REG = 8;
   localparam int SIZE_SHIFT0 = 2;
   localparam int EV_FAST = 0;
   localparam int EV_NORM = 1;
   // Levels below this one go to the fast request.
   localparam logic [2:0] LVL_NORM_MIN = 3'h2;
   // Reset values.
   localparam logic [63:0] ST_IDLE = 64'hffff_ffff_ffff_ffff;
   localparam logic [2:0] PRIO_RST = 3'h7;
   localparam logic [1:0] SIZE_RST = 2'h0;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/pic_top.sv]
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Takes 64 independent event inputs, the upper sixteen being external channels.
// - Each channel has a 3-bit level; 0 and 1 go fast, 2 to 7 normal.
// - Among fast events level 0 beats level 1.
// - Among normal events level 2 ranks highest, 7 lowest, numeric order between.
// - Equal levels are decided in favour of the smaller channel number.
// - An event is recorded in the fast or normal status bit its level selects.
// - Status capture happens whether or not the channel is enabled.
// - A captured event raises its request only while the channel is enabled.
// - The enable gates fast and normal channels the same way.
// - Each type's vector register shows the best pending enabled event's entry.
// - With several events pending the vector is the single highest ranked one.
// - Vector is base plus (event number plus one) times entry size 4/8/16/32.
// - With nothing pending of a type its vector reads the base unchanged.
// - Writing one to a status bit acknowledges it; writing zero leaves it.
module pic_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [63:0] evt_in,
   output logic fast_request,
   output logic normal_request,
   output logic irq,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   logic [63:0] fast_st_q, fast_st_d, norm_st_q, norm_st_d, en_q, en_d;
   logic [2:0] prio_q [0:63];
   logic [63:0] fast_rt, fast_eff, norm_eff, ack_fast, ack_norm;
   logic [1:0] size_q;
   logic [31:0] base_q, fvec_q, nvec_q, fvec_d, nvec_d;
   logic [1:0] evst_q, evst_d, evmask_q, ev_set;
   logic fast_request_q, normal_request_q, irq_q;
   logic awready_q, wready_q, awv_q, wv_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q, wmask, rd_mux;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic awv_d, wv_d, do_wr, ar_hs, rd_ok, wr_ok;
   logic [5:0] fast_win, norm_win;
   logic fast_any, norm_any;
   logic [2:0] fast_lvl, norm_lvl;
   logic [7:0] prio_off;

   // Write side: address and data are latched independently, then committed together.
   assign do_wr = awv_q & wv_q & ~bvalid_q;
   assign awv_d = (awv_q & ~do_wr) | (awvalid & awready_q);
   assign wv_d = (wv_q & ~do_wr) | (wvalid & wready_q);
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign ar_hs = arvalid & arready_q;
   assign wr_ok = (awaddr_q <= pic_pkg::OFF_BASE && awaddr_q[1:0] == 2'h0)
      || (awaddr_q >= pic_pkg::OFF_PRIO0 && awaddr_q <= pic_pkg::OFF_EVMASK
      && awaddr_q[1:0] == 2'h0);
   assign rd_ok = (araddr <= pic_pkg::OFF_BASE && araddr[1:0] == 2'h0)
      || (araddr >= pic_pkg::OFF_PRIO0 && araddr <= pic_pkg::OFF_EVMASK
      && araddr[1:0] == 2'h0);
   // Level words count from their own base, so the word index is taken from the offset.
   assign prio_off = araddr - pic_pkg::OFF_PRIO0;

   // Write-side handshake registers; awready, wready, bvalid and bresp come from these.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awv_q <= 1'b0;
         wv_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= pic_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         awv_q <= awv_d;
         wv_q <= wv_d;
         awready_q <= ~awv_d;
         wready_q <= ~wv_d;
         if (awvalid && awready_q) begin
            awaddr_q <= awaddr;
         end
         if (wvalid && wready_q) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read side: one read in flight, data captured at the address handshake.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= pic_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // Read selection; priority registers hold eight 4-bit fields, top bit reads zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (araddr)
         pic_pkg::OFF_FAST0: rd_mux = fast_st_q[31:0];
         pic_pkg::OFF_FAST1: rd_mux = fast_st_q[63:32];
         pic_pkg::OFF_NORM0: rd_mux = norm_st_q[31:0];
         pic_pkg::OFF_NORM1: rd_mux = norm_st_q[63:32];
         pic_pkg::OFF_FVEC: rd_mux = fvec_q;
         pic_pkg::OFF_NVEC: rd_mux = nvec_q;
         pic_pkg::OFF_EN0: rd_mux = en_q[31:0];
         pic_pkg::OFF_EN1: rd_mux = en_q[63:32];
         pic_pkg::OFF_CTL: rd_mux = {30'h0, size_q};
         pic_pkg::OFF_BASE: rd_mux = base_q;
         pic_pkg::OFF_EVST: rd_mux = {30'h0, evst_q};
         pic_pkg::OFF_EVMASK: rd_mux = {30'h0, evmask_q};
         default: begin
            if (rd_ok) begin
               for (int k = 0; k < pic_pkg::PRIO_PER_REG; k++) begin
                  rd_mux[k*pic_pkg::PRIO_NIB +: 3] = prio_q[{prio_off[4:2], 3'(k)}];
               end
            end
         end
      endcase
   end

   // ack decode: a one written to a status bit restores it to idle.
   assign ack_fast = {(do_wr && awaddr_q == pic_pkg::OFF_FAST1) ? wdata_q & wmask : 32'h0,
      (do_wr && awaddr_q == pic_pkg::OFF_FAST0) ? wdata_q & wmask : 32'h0};
   assign ack_norm = {(do_wr && awaddr_q == pic_pkg::OFF_NORM1) ? wdata_q & wmask : 32'h0,
      (do_wr && awaddr_q == pic_pkg::OFF_NORM0) ? wdata_q & wmask : 32'h0};

   // capture: status bits read zero when an event occurred, whatever the enable.
   // An event arriving together with its acknowledge is kept.
   assign fast_st_d = (fast_st_q | ack_fast) & ~(evt_in & fast_rt);
   assign norm_st_d = (norm_st_q | ack_norm) & ~(evt_in & ~fast_rt);
   assign en_d = {(do_wr && awaddr_q == pic_pkg::OFF_EN1)
      ? (en_q[63:32] & ~wmask) | (wdata_q & wmask) : en_q[63:32],
      (do_wr && awaddr_q == pic_pkg::OFF_EN0)
      ? (en_q[31:0] & ~wmask) | (wdata_q & wmask) : en_q[31:0]};

   // gate: one enable bit masks both request types alike.
   assign fast_eff = ~fast_st_q & en_q;
   assign norm_eff = ~norm_st_q & en_q;

   // per channel: level field storage and routing to fast or normal.
   for (genvar g = 0; g < pic_pkg::NCH; g++) begin : g_ch
      localparam logic [7:0] PADDR = pic_pkg::OFF_PRIO0 + 8'((g / 8) * 4);
      localparam int NIB = (g % 8) * pic_pkg::PRIO_NIB;
      assign fast_rt[g] = prio_q[g] < pic_pkg::LVL_NORM_MIN;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            prio_q[g] <= pic_pkg::PRIO_RST;
         end else if (do_wr && awaddr_q == PADDR && wstrb_q[NIB / 8]) begin
            prio_q[g] <= wdata_q[NIB +: 3];
         end
      end
   end

   // prioritizer: lowest level wins, ties go to the lower channel.
   always_comb begin
      fast_any = 1'b0;
      norm_any = 1'b0;
      fast_win = 6'h00;
      norm_win = 6'h00;
      fast_lvl = 3'h7;
      norm_lvl = 3'h7;
      for (int i = 0; i < pic_pkg::NCH; i++) begin
         if (fast_eff[i] && (!fast_any || prio_q[i] < fast_lvl)) begin
            fast_any = 1'b1;
            fast_win = 6'(i);
            fast_lvl = prio_q[i];
         end
         if (norm_eff[i] && (!norm_any || prio_q[i] < norm_lvl)) begin
            norm_any = 1'b1;
            norm_win = 6'(i);
            norm_lvl = prio_q[i];
         end
      end
   end

   // vectors: base plus (winner + 1) scaled by entry size, else base.
   assign fvec_d = fast_any
      ? base_q + ((32'(fast_win) + 32'h1) << (pic_pkg::SIZE_SHIFT0 + 32'(size_q))) : base_q;
   assign nvec_d = norm_any
      ? base_q + ((32'(norm_win) + 32'h1) << (pic_pkg::SIZE_SHIFT0 + 32'(size_q))) : base_q;

   // Host event flags: a rising request sets, a read clears, a new edge wins.
   assign ev_set = {fast_any & ~fast_request_q, norm_any & ~normal_request_q};
   assign evst_d = (ar_hs && araddr == pic_pkg::OFF_EVST) ? 2'h0 | {ev_set[0], ev_set[1]}
      : evst_q | {ev_set[0], ev_set[1]};

   // state: status, enables, vectors and requests update every cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fast_st_q <= pic_pkg::ST_IDLE;
         norm_st_q <= pic_pkg::ST_IDLE;
         en_q <= 64'h0;
         fast_request_q <= 1'b0;
         normal_request_q <= 1'b0;
         fvec_q <= pic_pkg::BASE_RST;
         nvec_q <= pic_pkg::BASE_RST;
         evst_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         fast_st_q <= fast_st_d;
         norm_st_q <= norm_st_d;
         en_q <= en_d;
         fast_request_q <= fast_any;
         normal_request_q <= norm_any;
         fvec_q <= fvec_d;
         nvec_q <= nvec_d;
         evst_q <= evst_d;
         irq_q <= |(evst_d & evmask_q);
      end
   end

   // Software-written configuration: entry size, table base, host event mask.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         size_q <= pic_pkg::SIZE_RST;
         base_q <= pic_pkg::BASE_RST;
         evmask_q <= 2'h0;
      end else if (do_wr && wstrb_q[0] && awaddr_q == pic_pkg::OFF_CTL) begin
         size_q <= wdata_q[pic_pkg::CTL_SIZE_LSB +: 2];
      end else if (do_wr && awaddr_q == pic_pkg::OFF_BASE) begin
         base_q <= (base_q & ~wmask) | (wdata_q & wmask);
      end else if (do_wr && wstrb_q[0] && awaddr_q == pic_pkg::OFF_EVMASK) begin
         evmask_q <= wdata_q[1:0];
      end
   end

   assign fast_request = fast_request_q;
   assign normal_request = normal_request_q;
   assign irq = irq_q;
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_fast_event;
      (evt_in & fast_rt) != 64'h0;
   endsequence

   a_fast_capture: assert property (s_fast_event |=>
      ((($past(evt_in) & $past(fast_rt)) & fast_st_q) == 64'h0))
      else $error("fast event not captured");
   a_norm_capture: assert property ((evt_in & ~fast_rt) != 64'h0 |=>
      ((($past(evt_in) & ~$past(fast_rt)) & norm_st_q) == 64'h0))
      else $error("normal event not captured");
   a_mask_gates_req: assert property (en_q == 64'h0 && $past(en_q) == 64'h0 |->
      !fast_request_q || $past(fast_request_q))
      else $error("request raised with all channels disabled");
   a_req_follows: assert property (((~fast_st_q & en_q) != 64'h0) |=> fast_request_q)
      else $error("fast request missing");
   a_ack_restores: assert property ((ack_fast != 64'h0 && evt_in == 64'h0) |=>
      ((fast_st_q & $past(ack_fast)) == $past(ack_fast)))
      else $error("acknowledge did not restore status");
   a_vec_idle: assert property (!norm_any |=> nvec_q == $past(base_q))
      else $error("idle normal vector not base");
   a_winner_valid: assert property (fast_any |-> fast_eff[fast_win]
      && (fast_win == 6'h00 || (fast_eff[fast_win - 6'h1] == 1'b0)
      || prio_q[fast_win - 6'h1] > prio_q[fast_win]))
      else $error("fast winner is not the best event");
   a_vec_value: assert property (fast_any && size_q == 2'h0 |=>
      fvec_q == $past(base_q) + 32'(({26'h0, $past(fast_win)} + 32'h1) * 4))
      else $error("fast vector value wrong");
   a_resp_hold: assert property (bvalid_q && !bready |=> bvalid_q)
      else $error("write response dropped early");
   a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
      fast_st_q == pic_pkg::ST_IDLE && en_q == 64'h0 && !fast_request_q && !normal_request_q)
      else $error("reset state not idle");
endmodule

// [tb/pic_core_model.sv]
`timescale 1ns/1ps
// Core side of the request lines: counts handler entries, one per rising request level.
module pic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fast_request,
   input wire logic normal_request,
   output int fast_entries,
   output int normal_entries
);
   logic fast_q;
   logic normal_q;
   // Edge detection on both request lines; reset forgets any earlier history.
   always_ff @(posedge aclk) begin
      fast_q <= aresetn & fast_request;
      normal_q <= aresetn & normal_request;
      if (!aresetn) begin
         fast_entries <= 0;
         normal_entries <= 0;
      end else begin
         fast_entries <= fast_entries + int'(fast_request & !fast_q);
         normal_entries <= normal_entries + int'(normal_request & !normal_q);
      end
   end
endmodule

// [tb/tb_prioritized_interrupt_controller.sv]
`timescale 1ns/1ps
module tb_prioritized_interrupt_controller;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, fast_request, normal_request, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   logic [63:0] evt_in;
   int n_mismatch = 0;
   int n_tests = 0;
   int fast_entries, normal_entries;
   localparam logic [31:0] tbl_base = 32'h0000_1000;

   pic_top i_dut (.aclk(aclk), .aresetn(aresetn), .evt_in(evt_in), .fast_request(fast_request),
      .normal_request(normal_request), .irq(irq), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   pic_core_model i_core (.aclk(aclk), .aresetn(aresetn), .fast_request(fast_request),
      .normal_request(normal_request), .fast_entries(fast_entries),
      .normal_entries(normal_entries));

   // Free-running system clock.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic end_of_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One write: address and data offered together, each released once it is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ad;
      bit wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready && !ad) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (wready && !wd) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end while (!(ad && wd));
      while (!bvalid) @(posedge aclk);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   // One read; the answer is taken at the edge where rvalid is seen high.
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] ex, input string nm);
      rd(a);
      chk(nm, ex, rd_data);
   endtask

   // Sets one channel's level; the other seven channels of that word go back to level 7.
   task automatic set_prio(input int ch, input logic [2:0] lvl);
      logic [31:0] w;
      w = 32'h7777_7777;
      w[(ch % 8) * 4 +: 3] = lvl;
      wr(pic_pkg::OFF_PRIO0 + 8'(4 * (ch / 8)), w);
   endtask

   // One-cycle event burst, then time for capture and request to settle.
   task automatic pulse(input logic [63:0] m);
      @(posedge aclk);
      evt_in <= m;
      @(posedge aclk);
      evt_in <= 64'h0;
      repeat (4) @(posedge aclk);
   endtask

   task automatic t_reset;
      chk("fast_request", 32'h0, {31'h0, fast_request});
      chk("normal_request", 32'h0, {31'h0, normal_request});
      rc(pic_pkg::OFF_FAST0, 32'hffff_ffff, "fast status 0");
      rc(pic_pkg::OFF_NORM1, 32'hffff_ffff, "normal status 1");
      rc(pic_pkg::OFF_EN0, 32'h0, "enable 0");
      chk("read resp", {30'h0, pic_pkg::RESP_OKAY}, {30'h0, rd_resp});
      rc(pic_pkg::OFF_PRIO7, 32'h7777_7777, "priority 7");
      rc(pic_pkg::OFF_NVEC, 32'h0, "normal vector idle");
      rd(8'h28);
      chk("unmapped read resp", {30'h0, pic_pkg::RESP_SLVERR}, {30'h0, rd_resp});
      chk("unmapped read data", 32'h0, rd_data);
      wr(8'h2c, 32'hffff_ffff);
      chk("unmapped write resp", {30'h0, pic_pkg::RESP_SLVERR}, {30'h0, wr_resp});
   endtask

   task automatic t_fast;
      wr(pic_pkg::OFF_BASE, tbl_base);
      chk("write resp", {30'h0, pic_pkg::RESP_OKAY}, {30'h0, wr_resp});
      set_prio(5, 3'h1);
      set_prio(9, 3'h0);
      wr(pic_pkg::OFF_EN0, 32'h0000_0220);
      pulse(64'h220);
      rc(pic_pkg::OFF_FAST0, ~32'h220, "fast status 0");
      rc(pic_pkg::OFF_NORM0, 32'hffff_ffff, "normal status 0");
      chk("fast_request", 32'h1, {31'h0, fast_request});
      chk("normal_request", 32'h0, {31'h0, normal_request});
      rc(pic_pkg::OFF_FVEC, tbl_base + 32'd10 * 4, "fast vector");
      wr(pic_pkg::OFF_FAST0, 32'h0);
      rc(pic_pkg::OFF_FAST0, ~32'h220, "fast status 0");
      wr(pic_pkg::OFF_FAST0, 32'h200);
      rc(pic_pkg::OFF_FVEC, tbl_base + 32'd6 * 4, "fast vector");
      wr(pic_pkg::OFF_FAST0, 32'h20);
      rc(pic_pkg::OFF_FVEC, tbl_base, "fast vector");
      chk("fast_request", 32'h0, {31'h0, fast_request});
      chk("fast entries", 32'd1, fast_entries);
   endtask

   task automatic t_norm;
      set_prio(40, 3'h3);
      set_prio(50, 3'h2);
      set_prio(57, 3'h2);
      rc(pic_pkg::OFF_PRIO0 + 8'h14, 32'h7777_7773, "priority 5");
      wr(pic_pkg::OFF_EN1, 32'hffff_ffff);
      pulse((64'h1 << 40) | (64'h1 << 50) | (64'h1 << 57));
      rc(pic_pkg::OFF_NORM1, ~32'h0204_0100, "normal status 1");
      rc(pic_pkg::OFF_FAST1, 32'hffff_ffff, "fast status 1");
      chk("normal_request", 32'h1, {31'h0, normal_request});
      for (int s = 0; s < 4; s++) begin
         wr(pic_pkg::OFF_CTL, 32'(s));
         rc(pic_pkg::OFF_NVEC, tbl_base + 32'd51 * (32'd4 << s), "normal vector");
      end
      wr(pic_pkg::OFF_CTL, 32'h0);
      wr(pic_pkg::OFF_NORM1, 32'h0004_0000);
      rc(pic_pkg::OFF_NVEC, tbl_base + 32'd58 * 4, "normal vector");
      wr(pic_pkg::OFF_NORM1, 32'h0200_0000);
      rc(pic_pkg::OFF_NVEC, tbl_base + 32'd41 * 4, "normal vector");
      wr(pic_pkg::OFF_NORM1, 32'h0000_0100);
      rc(pic_pkg::OFF_NVEC, tbl_base, "normal vector");
      chk("normal_request", 32'h0, {31'h0, normal_request});
      chk("normal entries", 32'd1, normal_entries);
      wr(pic_pkg::OFF_EN1, 32'h0);
   endtask

   task automatic t_mask;
      set_prio(63, 3'h0);
      pulse(64'h1 << 63);
      rc(pic_pkg::OFF_FAST1, 32'h7fff_ffff, "fast status 1");
      chk("fast_request", 32'h0, {31'h0, fast_request});
      rc(pic_pkg::OFF_FVEC, tbl_base, "fast vector");
      wr(pic_pkg::OFF_EN1, 32'h8000_0000);
      rc(pic_pkg::OFF_FVEC, tbl_base + 32'd64 * 4, "fast vector");
      chk("fast_request", 32'h1, {31'h0, fast_request});
      wr(pic_pkg::OFF_FAST1, 32'h8000_0000);
      wr(pic_pkg::OFF_EN1, 32'h0);
      pulse(64'h1);
      rc(pic_pkg::OFF_NORM0, 32'hffff_fffe, "normal status 0");
      chk("normal_request", 32'h0, {31'h0, normal_request});
      wr(pic_pkg::OFF_NORM0, 32'h1);
      chk("fast entries", 32'd2, fast_entries);
   endtask

   task automatic t_irq;
      rd(pic_pkg::OFF_EVST);
      wr(pic_pkg::OFF_EVMASK, 32'h1);
      wr(pic_pkg::OFF_EN0, 32'h20);
      pulse(64'h20);
      chk("irq", 32'h1, {31'h0, irq});
      rc(pic_pkg::OFF_EVST, 32'h1, "event status");
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(pic_pkg::OFF_FAST0, 32'h20);
      wr(pic_pkg::OFF_EVMASK, 32'h0);
      pulse(64'h20);
      chk("irq", 32'h0, {31'h0, irq});
      rc(pic_pkg::OFF_EVST, 32'h1, "event status");
      wr(pic_pkg::OFF_FAST0, 32'h20);
   endtask

   // Inputs idle at time zero, reset for ten cycles, then the scenarios in turn.
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      evt_in = 64'h0;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_reset;
      t_fast;
      t_norm;
      t_mask;
      t_irq;
      end_of_test;
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_of_test;
   end
endmodule
